// [hw/hpp_host_port.sv]
// Parallel host port with firmware register file over classic Wishbone
// Functional notes
// - Mode bit makes port D host-accessible slave
// - Port E pins: read, store, select
// - One address: write outbound, read inbound
// - Port D direction ignored in host mode
// - Select and store low capture inbound byte
// - Inbound full set phase four after end
// - Interrupt flag set with inbound full
// - In host mode only firmware inbound read clears inbound full
// - Write before firmware read sets overrun
// - Select and read low clear outbound full
// - Read end sets interrupt flag phase four
// - Outbound full stays low until firmware write
// - Outside mode full flags cleared, overrun kept
// - Flag latched; interrupt only when enabled
// - Read strobe active low with select
// - Store strobe active low with select
`timescale 1ns/1ns
`include "hpp_defs.svh"
module hpp_host_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] port_d_i,
    output hpp_pkg::hpp_byte_t port_d_o,
    output logic [7:0] port_d_oe_o,
    input wire logic [2:0] port_e_i,
    output logic [2:0] port_e_o,
    output logic [2:0] port_e_oe_o,
    output logic irq_o
);
    import hpp_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [7:0] d_meta;
    logic [7:0] d_sync;
    logic [2:0] e_meta;
    logic [2:0] e_sync;
    always_ff @(posedge clk_i) begin
        d_meta <= port_d_i;
        d_sync <= d_meta;
        e_meta <= port_e_i;
        e_sync <= e_meta;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic host_port_mode_sel;
    logic inbound_full;
    logic outbound_full;
    logic inbound_overrun;
    logic [2:0] port_e_direction;
    logic [2:0] port_e_latch;
    logic [2:0] analog_pin_select;
    logic [7:0] port_d_direction;
    logic [7:0] periph_irq_flags;
    logic [7:0] periph_irq_enables;
    hpp_byte_t outbound_latch;
    hpp_byte_t inbound_latch;

    logic rd_n;
    logic wr_n;
    logic cs_n;
    assign rd_n = e_sync[0];
    assign wr_n = e_sync[1];
    assign cs_n = e_sync[2];

    logic wb_req;
    logic wb_fin;
    logic wb_wr;
    logic wb_rd;
    assign wb_req = cyc_i && stb_i && !ack_o;
    // Side effects land on the edge at which the master sees ack
    assign wb_fin = cyc_i && stb_i && ack_o;
    assign wb_wr = wb_fin && we_i && sel_i[0];
    assign wb_rd = wb_req && !we_i;

    logic fw_wr_pd;
    logic fw_rd_pd;
    assign fw_wr_pd = wb_wr && (adr_i == `HPP_OFS_PORT_D_DATA);
    assign fw_rd_pd = wb_fin && !we_i && (adr_i == `HPP_OFS_PORT_D_DATA);

    // ************************************************************
    // Host strobe sequencing
    // ************************************************************
    hpp_xfer_t wr_state;
    hpp_xfer_t rd_state;
    logic [1:0] wr_phase;
    logic [1:0] rd_phase;
    logic wr_start;
    logic rd_start;
    logic wr_done;
    logic rd_done;
    logic wr_active;
    logic rd_active;
    assign wr_active = host_port_mode_sel && !cs_n && !wr_n;
    assign rd_active = host_port_mode_sel && !cs_n && !rd_n;
    assign wr_start = (wr_state == HPP_IDLE) && wr_active;
    assign rd_start = (rd_state == HPP_IDLE) && rd_active;
    // Completion lands on phase four, after the following phase two
    assign wr_done = (wr_state == HPP_DONE) && (wr_phase == `HPP_PHASES);
    assign rd_done = (rd_state == HPP_DONE) && (rd_phase == `HPP_PHASES);

    always_ff @(posedge clk_i) begin
        if (rst_i || !host_port_mode_sel) begin
            wr_state <= HPP_IDLE;
            wr_phase <= 2'h0;
        end else begin
            unique case (wr_state)
                HPP_IDLE: begin
                    if (wr_active) begin
                        wr_state <= HPP_BUSY;
                    end
                end
                HPP_BUSY: begin
                    if (!wr_active) begin
                        wr_state <= HPP_DONE;
                        wr_phase <= 2'h0;
                    end
                end
                HPP_DONE: begin
                    wr_phase <= wr_phase + 2'h1;
                    if (wr_done) begin
                        wr_state <= HPP_IDLE;
                    end
                end
                default: wr_state <= HPP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !host_port_mode_sel) begin
            rd_state <= HPP_IDLE;
            rd_phase <= 2'h0;
        end else begin
            unique case (rd_state)
                HPP_IDLE: begin
                    if (rd_active) begin
                        rd_state <= HPP_BUSY;
                    end
                end
                HPP_BUSY: begin
                    if (!rd_active) begin
                        rd_state <= HPP_DONE;
                        rd_phase <= 2'h0;
                    end
                end
                HPP_DONE: begin
                    rd_phase <= rd_phase + 2'h1;
                    if (rd_done) begin
                        rd_state <= HPP_IDLE;
                    end
                end
                default: rd_state <= HPP_IDLE;
            endcase
        end
    end

    // Inbound byte capture while the store strobe is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inbound_latch <= `HPP_RST_BYTE;
        end else if (wr_active) begin
            inbound_latch <= d_sync;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !host_port_mode_sel) begin
            inbound_full <= 1'b0;
        end else if (wr_done) begin
            inbound_full <= 1'b1;
        end else if (fw_rd_pd) begin
            inbound_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !host_port_mode_sel) begin
            outbound_full <= 1'b0;
        end else if (rd_start) begin
            outbound_full <= 1'b0;
        end else if (fw_wr_pd) begin
            outbound_full <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inbound_overrun <= 1'b0;
        end else if (wr_start && inbound_full) begin
            inbound_overrun <= 1'b1;
        end else if (wb_wr && adr_i == `HPP_OFS_PORT_E_DIR
                     && !dat_i[`HPP_BIT_INBOUND_OVERRUN]) begin
            inbound_overrun <= 1'b0;
        end
    end

    // ************************************************************
    // Firmware registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_port_mode_sel <= 1'b0;
            port_e_direction <= `HPP_RST_PORT_E_DIR;
            analog_pin_select <= `HPP_RST_ANALOG_CFG;
            port_d_direction <= `HPP_RST_PORT_D_DIR;
            port_e_latch <= 3'h0;
            periph_irq_enables <= `HPP_RST_IRQ_ENABLES;
            outbound_latch <= `HPP_RST_BYTE;
        end else if (wb_wr) begin
            unique case (adr_i)
                `HPP_OFS_PORT_D_DATA: outbound_latch <= dat_i[7:0];
                `HPP_OFS_PORT_E_PINS: port_e_latch <= dat_i[2:0];
                `HPP_OFS_PORT_E_DIR: begin
                    host_port_mode_sel <= dat_i[`HPP_BIT_MODE];
                    port_e_direction <= dat_i[2:0];
                end
                `HPP_OFS_IRQ_ENABLES: periph_irq_enables <= dat_i[7:0];
                `HPP_OFS_ANALOG_CFG: analog_pin_select <= dat_i[2:0];
                `HPP_OFS_PORT_D_DIR: port_d_direction <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Hardware set wins over firmware clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_irq_flags <= `HPP_RST_IRQ_FLAGS;
        end else begin
            if (wb_wr && adr_i == `HPP_OFS_IRQ_FLAGS) begin
                periph_irq_flags <= dat_i[7:0];
            end
            if (wr_done || rd_done) begin
                periph_irq_flags[`HPP_BIT_HP_IRQ] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Bus answer, pins and interrupt
    // ************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        unique case (adr_i)
            `HPP_OFS_PORT_D_DATA: rd_byte = host_port_mode_sel ? inbound_latch : d_sync;
            `HPP_OFS_PORT_E_PINS: rd_byte = {5'h00, e_sync};
            `HPP_OFS_IRQ_FLAGS: rd_byte = periph_irq_flags;
            `HPP_OFS_PORT_E_DIR: rd_byte = {inbound_full, outbound_full, inbound_overrun,
                                            host_port_mode_sel, 1'b0, port_e_direction};
            `HPP_OFS_IRQ_ENABLES: rd_byte = periph_irq_enables;
            `HPP_OFS_ANALOG_CFG: rd_byte = {5'h00, analog_pin_select};
            `HPP_OFS_PORT_D_DIR: rd_byte = port_d_direction;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            dat_o <= wb_rd ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_d_o <= `HPP_RST_BYTE;
            port_d_oe_o <= 8'h00;
            port_e_o <= 3'h0;
            port_e_oe_o <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            port_d_o <= outbound_latch;
            if (host_port_mode_sel) begin
                port_d_oe_o <= rd_active ? 8'hFF : 8'h00;
                port_e_oe_o <= 3'h0;
            end else begin
                port_d_oe_o <= ~port_d_direction;
                port_e_oe_o <= ~port_e_direction;
            end
            port_e_o <= port_e_latch;
            irq_o <= periph_irq_flags[`HPP_BIT_HP_IRQ]
                     && periph_irq_enables[`HPP_BIT_HP_IRQ];
        end
    end
endmodule // hpp_host_port

// [pkg/hpp_defs.svh]
// Register offsets, field positions and reset values of the host port
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH
`define HPP_OFS_PORT_D_DATA 8'h08
`define HPP_OFS_PORT_E_PINS 8'h09
`define HPP_OFS_IRQ_FLAGS 8'h0C
`define HPP_OFS_PORT_E_DIR 8'h89
`define HPP_OFS_IRQ_ENABLES 8'h8C
`define HPP_OFS_ANALOG_CFG 8'h9F
`define HPP_OFS_PORT_D_DIR 8'h88
`define HPP_BIT_INBOUND_FULL 7
`define HPP_BIT_OUTBOUND_FULL 6
`define HPP_BIT_INBOUND_OVERRUN 5
`define HPP_BIT_MODE 4
`define HPP_BIT_HP_IRQ 7
`define HPP_RST_PORT_E_DIR 3'h7
`define HPP_RST_IRQ_FLAGS 8'h00
`define HPP_RST_IRQ_ENABLES 8'h00
`define HPP_RST_ANALOG_CFG 3'h0
`define HPP_RST_PORT_D_DIR 8'hFF
`define HPP_RST_BYTE 8'h00
`define HPP_PHASES 2'h3
`endif

// [pkg/hpp_pkg.sv]
// Types shared by the host port design
package hpp_pkg;
    typedef enum logic [2:0] {
        HPP_IDLE = 3'b001,
        HPP_BUSY = 3'b010,
        HPP_DONE = 3'b100
    } hpp_xfer_t;
    typedef logic [7:0] hpp_byte_t;
endpackage

// [tb/hpp_checker.sv]
// Port-level assertions for the host port
`timescale 1ns/1ns
module hpp_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [7:0] port_d_o,
    input wire logic [7:0] port_d_oe_o,
    input wire logic [2:0] port_e_i,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged after one cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    AST_DAT_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_OE_WHOLE: assert property (port_d_oe_o == 8'h00 || port_d_oe_o == 8'hFF)
        else $error("data pins partly driven");
    AST_OE_IDLE: assert property ((port_e_i[0] || port_e_i[2]) [*5] |-> port_d_oe_o == 8'h00)
        else $error("data pins driven without host read");
    AST_OE_CAUSE: assert property ($rose(port_d_oe_o[0]) |-> !port_e_i[0] && !port_e_i[2])
        else $error("drive started without select and read low");
    AST_DATA_HOLD: assert property (port_d_oe_o[0] && $past(port_d_oe_o[0]) |-> $stable(port_d_o))
        else $error("driven byte changed during host read");
    AST_IRQ_HOLD: assert property ($fell(irq_o) |-> $past(cyc_i && we_i, 2) || $past(cyc_i && we_i, 3))
        else $error("interrupt dropped without firmware write");
endmodule // hpp_checker

// [tb/hpp_host_model.sv]
// Model of the external processor on the host port pins
`timescale 1ns/1ns
module hpp_host_model (
    input wire logic clk_i,
    input hpp_pkg::hpp_byte_t dev_data_i,
    input wire logic [7:0] dev_oe_i,
    output logic [2:0] strobe_n_o,
    output hpp_pkg::hpp_byte_t data_o
);
    import hpp_pkg::*;
    logic host_drv = 1'b0;
    hpp_byte_t host_val = 8'h00;
    hpp_byte_t last_val = 8'h00;
    initial strobe_n_o = 3'h7;
    // Released bus shows the inverse of its last level
    always_comb begin
        if (host_drv) data_o = host_val;
        else if (dev_oe_i == 8'hFF) data_o = dev_data_i;
        else data_o = ~last_val;
    end
    always_ff @(posedge clk_i) begin
        if (host_drv || dev_oe_i == 8'hFF) last_val <= data_o;
    end
    task automatic write_byte(input hpp_byte_t val, input int hold);
        @(posedge clk_i);
        host_drv <= 1'b1;
        host_val <= val;
        strobe_n_o <= 3'b001;
        repeat (hold) @(posedge clk_i);
        strobe_n_o <= 3'b111;
        repeat (2) @(posedge clk_i);
        host_drv <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic read_byte(input int hold, output hpp_byte_t val);
        @(posedge clk_i);
        strobe_n_o <= 3'b010;
        repeat (hold) @(posedge clk_i);
        val = data_o;
        strobe_n_o <= 3'b111;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // hpp_host_model

// [tb/tb_top.sv]
// Self-checking bench for the host port
`timescale 1ns/1ns
`include "hpp_defs.svh"
module tb_top;
    import hpp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [7:0] port_d_i;
    hpp_byte_t port_d_o;
    logic [7:0] port_d_oe_o;
    logic [2:0] port_e_i;
    logic irq_o;
    logic [2:0] port_e_o;
    logic [2:0] port_e_oe_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    hpp_byte_t got;
    always #5 clk_i = ~clk_i;
    hpp_host_port hpp_host_port_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .port_d_i, .port_d_o, .port_d_oe_o, .port_e_i,
        .port_e_o, .port_e_oe_o, .irq_o);
    hpp_host_model hpp_host_model_inst (.clk_i, .dev_data_i(port_d_o), .dev_oe_i(port_d_oe_o),
        .strobe_n_o(port_e_i), .data_o(port_d_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r, {24'h0, e});
    endtask
    task automatic t_reset;
        rd(`HPP_OFS_PORT_E_DIR, 8'h07);
        rd(`HPP_OFS_IRQ_FLAGS, 8'h00);
        rd(`HPP_OFS_IRQ_ENABLES, 8'h00);
        rd(`HPP_OFS_ANALOG_CFG, 8'h00);
        rd(8'h55, 8'h00);
        wr(`HPP_OFS_PORT_E_PINS, 8'h05);
        repeat (2) @(posedge clk_i);
        chk(32'(port_e_o), 32'h5);
        chk(32'(port_e_oe_o), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_write;
        wr(`HPP_OFS_ANALOG_CFG, 8'h07);
        wr(`HPP_OFS_PORT_E_DIR, 8'h17);
        wr(`HPP_OFS_PORT_D_DIR, 8'h00);
        hpp_host_model_inst.write_byte(8'hA5, 4);
        rd(`HPP_OFS_PORT_E_DIR, 8'h97);
        rd(`HPP_OFS_IRQ_FLAGS, 8'h80);
        hpp_host_model_inst.write_byte(8'h3C, 9);
        rd(`HPP_OFS_PORT_E_DIR, 8'hB7);
        rd(`HPP_OFS_PORT_D_DATA, 8'h3C);
        rd(`HPP_OFS_PORT_E_DIR, 8'h37);
        wr(`HPP_OFS_PORT_E_DIR, 8'h17);
        rd(`HPP_OFS_PORT_E_DIR, 8'h17);
        $display("test write done");
    endtask
    task automatic t_irq;
        chk(32'(irq_o), 32'h0);
        wr(`HPP_OFS_IRQ_ENABLES, 8'h80);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        wr(`HPP_OFS_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        wr(`HPP_OFS_IRQ_ENABLES, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_read;
        wr(`HPP_OFS_PORT_D_DATA, 8'h5A);
        rd(`HPP_OFS_PORT_E_DIR, 8'h57);
        hpp_host_model_inst.read_byte(6, got);
        chk({24'h0, got}, 32'h5A);
        rd(`HPP_OFS_PORT_E_DIR, 8'h17);
        rd(`HPP_OFS_IRQ_FLAGS, 8'h80);
        wr(`HPP_OFS_IRQ_FLAGS, 8'h00);
        hpp_host_model_inst.read_byte(10, got);
        chk({24'h0, got}, 32'h5A);
        rd(`HPP_OFS_PORT_E_DIR, 8'h17);
        wr(`HPP_OFS_IRQ_FLAGS, 8'h00);
        wr(`HPP_OFS_PORT_D_DIR, 8'hFF);
        $display("test read done");
    endtask
    task automatic t_off;
        hpp_host_model_inst.write_byte(8'h11, 4);
        hpp_host_model_inst.write_byte(8'h22, 4);
        wr(`HPP_OFS_IRQ_FLAGS, 8'h00);
        wr(`HPP_OFS_PORT_D_DATA, 8'h66);
        rd(`HPP_OFS_PORT_E_DIR, 8'hF7);
        wr(`HPP_OFS_PORT_E_DIR, 8'h27);
        rd(`HPP_OFS_PORT_E_DIR, 8'h27);
        hpp_host_model_inst.write_byte(8'h33, 4);
        rd(`HPP_OFS_IRQ_FLAGS, 8'h00);
        rd(`HPP_OFS_PORT_E_DIR, 8'h27);
        $display("test mode off done");
    endtask
    task automatic t_again;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`HPP_OFS_PORT_E_DIR, 8'h07);
        rd(`HPP_OFS_IRQ_FLAGS, 8'h00);
        $display("test second reset done");
    endtask
    task automatic conclude;
        $display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_write();
        t_irq();
        t_read();
        t_off();
        t_again();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule // tb_top
bind hpp_host_port hpp_checker hpp_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .dat_o, .ack_o, .port_d_o, .port_d_oe_o, .port_e_i, .irq_o);
